/* File: bench/tsl_lockout_chk.sv */
// Port-level assertions for the lockout block
`timescale 1ns/100ps
`default_nettype none
module tsl_lockout_chk #(
    parameter int NUM_PARTS = 4,
    parameter int POS_W = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Tamper, self-test and identification
    input wire logic enclosureOpen,
    input wire logic backupFail,
    input wire logic retainedTamper,
    input wire logic tamperLatchSet,
    input wire logic selfTestDone,
    input wire logic [NUM_PARTS-1:0] selfTestFail,
    input wire logic edidCopyEnable,
    input wire logic edidHostWrite,
    input wire logic edidWriteBlock,
    // Switch and indications
    input wire logic [POS_W-1:0] switchPosition,
    input wire logic [NUM_PARTS-1:0] partEnable,
    input wire logic tamperLed,
    input wire logic failLed,
    input wire logic progPortLock
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic copyPrev;
    logic copyRose;
    logic passSeen;
    // History since reset
    always_ff @(posedge clock) begin
        if (reset) begin
            copyPrev <= 1'b0;
            copyRose <= 1'b0;
            passSeen <= 1'b0;
        end else begin
            copyPrev <= edidCopyEnable;
            copyRose <= copyRose | (edidCopyEnable & ~copyPrev);
            passSeen <= passSeen | (selfTestDone & ~|selfTestFail);
        end
    end
    sequence s_pass_done;
        selfTestDone && selfTestFail == '0 && !tamperLed;
    endsequence
    sequence s_bad_done;
        selfTestDone && selfTestFail != '0 && !tamperLed;
    endsequence
    a_write_block: assert property (edidHostWrite |-> edidWriteBlock)
        else $error("host write not blocked");
    a_tamper_isolate: assert property (tamperLed |-> ##1 (switchPosition == '0 && partEnable == '0 && progPortLock))
        else $error("tampered but not isolated");
    a_tamper_sticky: assert property (tamperLed |=> tamperLed && tamperLatchSet)
        else $error("tamper state lost");
    a_pin_tamper: assert property (enclosureOpen || backupFail || retainedTamper |-> ##[1:10] tamperLed)
        else $error("tamper pin ignored");
    a_fail_isolate: assert property (failLed |-> switchPosition == '0)
        else $error("failed but switch connected");
    a_fail_led: assert property (s_bad_done |-> ##2 failLed)
        else $error("failure not indicated");
    a_pass_copy: assert property (s_pass_done |=> edidCopyEnable && switchPosition == '0)
        else $error("copy not started after pass");
    a_copy_once: assert property (edidCopyEnable && !copyPrev |-> !copyRose)
        else $error("second copy window");
    a_switch_pass: assert property (switchPosition != '0 |-> passSeen)
        else $error("switch left isolation early");
endmodule
bind tsl_lockout tsl_lockout_chk #(.NUM_PARTS(NUM_PARTS), .POS_W(POS_W)) chk (.*);
`default_nettype wire

/* File: bench/tsl_lockout_tb.sv */
// Self-checking bench for the lockout block
`timescale 1ns/100ps
`default_nettype none
module tsl_lockout_tb
    import tsl_pkg::*;
;
    logic clock, reset, hsel, hwrite, hreadyout, hresp, rdPh, irq, silent, wipe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, switchPosition, expSw;
    logic [3:0] selfTestFail, partEnable, failVec, delay, fv;
    logic enclosureOpen, backupFail, retainedTamper, tamperLatchSet, selfTestStart, selfTestDone;
    logic edidCopyEnable, edidCopyDone, edidHostWrite, edidWriteBlock, tamperLed, failLed, progPortLock;
    logic [31:0] expQ[$], mskQ[$];
    int error_cnt, checks_done, seed, hostSel;

    tsl_lockout #(.STEP_TIMEOUT(50)) uut (.*, .hready(hreadyout), .hsize(3'h2));
    tsl_partner partner (.*);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read results checked where the data phase ends
    always @(posedge clock) begin
        if (rdPh && hreadyout === 1'b1 && expQ.size() > 0) begin
            check(hrdata & mskQ.pop_front(), expQ.pop_front(), "hrdata");
            check(32'(hresp), 32'h0000_0000, "hresp");
        end
        rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    function automatic logic cond(input int k);
        case (k)
            0: return switchPosition === expSw;
            1: return failLed === 1'b1;
            2: return tamperLed === 1'b1;
            3: return irq === 1'b1;
            default: return irq === 1'b0;
        endcase
    endfunction

    task automatic waitFor(input int k);
        int n;
        n = 0;
        while (!cond(k) && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        if (!w) begin
            expQ.push_back(d & m);
            mskQ.push_back(m);
        end
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask

    task automatic boot(input logic [3:0] f, input logic s, input logic w);
        failVec <= f;
        silent <= s;
        wipe <= w;
        delay <= 4'($random(seed)) | 4'h1;
        reset <= 1'b1;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        wipe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic pins(input logic [1:0] sw, input logic [3:0] pe, input logic fl, input logic tl);
        check(32'({failLed, tamperLed, partEnable, switchPosition}), 32'({fl, tl, pe, sw}), "pins");
    endtask

    task automatic hostWrite;
        edidHostWrite <= 1'b1;
        @(posedge clock);
        edidHostWrite <= 1'b0;
        @(posedge clock);
    endtask

    initial begin
        seed = 9;
        error_cnt = 0;
        checks_done = 0;
        expSw = 2'h1;
        hsel <= 1'b0;
        haddr <= 32'h0000_0000;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= 32'h0000_0000;
        enclosureOpen <= 1'b0;
        backupFail <= 1'b0;
        edidHostWrite <= 1'b0;
        boot(4'h0, 1'b0, 1'b1);
        waitFor(0);
        pins(2'h1, 4'hF, 1'b0, 1'b0);
        check(32'({edidCopyEnable, edidWriteBlock}), 32'h0000_0001, "edid");
        ahb(TSL_OFF_STATE, 1'b0, 32'h0000_0023, 32'h0000_007F);
        ahb(TSL_OFF_IRQ_STATUS, 1'b0, 32'h0000_000C, 32'h0000_001F);
        ahb(TSL_OFF_CONTROL, 1'b0, TSL_CONTROL_RESET, 32'hFFFF_FFFF);
        ahb(8'h14, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF);
        ahb(TSL_OFF_STATE, 1'b1, 32'hFFFF_FFFF, '0);
        ahb(TSL_OFF_STATE, 1'b0, 32'h0000_0023, 32'h0000_007F);
        hostSel = 1 + ($random(seed) & 1);
        expSw = 2'(hostSel);
        ahb(TSL_OFF_CONTROL, 1'b1, 32'h0000_0100 | 32'(hostSel), '0);
        waitFor(0);
        // Lock output follows the control write a cycle late
        repeat (2) @(posedge clock);
        check(32'(progPortLock), 32'h0000_0000, "lock");
        ahb(TSL_OFF_IRQ_ENABLE, 1'b1, 32'h0000_0010, '0);
        ahb(TSL_OFF_IRQ_ENABLE, 1'b0, 32'h0000_0010, 32'hFFFF_FFFF);
        hostWrite();
        waitFor(3);
        ahb(TSL_OFF_IRQ_CLEAR, 1'b1, 32'h0000_001F, '0);
        waitFor(4);
        ahb(TSL_OFF_IRQ_ENABLE, 1'b1, 32'h0000_0000, '0);
        hostWrite();
        repeat (4) @(posedge clock);
        check(32'(irq), 32'h0000_0000, "masked irq");
        ahb(TSL_OFF_IRQ_STATUS, 1'b0, 32'h0000_0010, 32'h0000_001F);
        ahb(TSL_OFF_IRQ_ENABLE, 1'b1, 32'h0000_0011, '0);
        waitFor(3);
        ahb(TSL_OFF_IRQ_CLEAR, 1'b1, 32'h0000_0010, '0);
        waitFor(4);
        // Pin pulse only: the lockout must hold on its own
        enclosureOpen <= 1'b1;
        waitFor(2);
        enclosureOpen <= 1'b0;
        repeat (20) @(posedge clock);
        pins(2'h0, 4'h0, 1'b0, 1'b1);
        check(32'({progPortLock, tamperLatchSet, irq}), 32'h0000_0007, "tamper outs");
        ahb(TSL_OFF_STATE, 1'b0, 32'h0000_0015, 32'h0000_001F);
        boot(4'h0, 1'b0, 1'b0);
        waitFor(2);
        pins(2'h0, 4'h0, 1'b0, 1'b1);
        backupFail <= 1'b1;
        boot(4'h0, 1'b0, 1'b1);
        waitFor(2);
        backupFail <= 1'b0;
        repeat (20) @(posedge clock);
        pins(2'h0, 4'h0, 1'b0, 1'b1);
        // Critical part, non-critical part, then no answer at all
        for (int i = 0; i < 3; i++) begin
            fv = (i == 0) ? 4'(($random(seed) & 2) | 1) : (i == 1) ? 4'(4 << ($random(seed) & 1)) : 4'hF;
            boot(fv, i == 2, 1'b1);
            waitFor(1);
            repeat (2) @(posedge clock);
            pins(2'h0, ((fv & 4'h3) != 4'h0) ? 4'h0 : ~fv, 1'b1, 1'b0);
            ahb(TSL_OFF_STATE, 1'b0, {20'h0_0000, fv, 8'h04} | ((i == 2) ? 32'h0000_0040 : '0), 32'h0000_0F7F);
        end
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: bench/tsl_partner.sv */
// Self-test engines, display copier and backup tamper latch
`timescale 1ns/100ps
`default_nettype none
module tsl_partner #(
    parameter int NUM_PARTS = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Scenario controls
    input wire logic [NUM_PARTS-1:0] failVec,
    input wire logic silent,
    input wire logic [3:0] delay,
    input wire logic wipe,
    // Lockout side
    input wire logic selfTestStart,
    input wire logic edidCopyEnable,
    input wire logic tamperLatchSet,
    output logic selfTestDone,
    output logic [NUM_PARTS-1:0] selfTestFail,
    output logic edidCopyDone,
    output logic retainedTamper
);
    logic [4:0] testCnt;
    logic [4:0] copyCnt;
    // Backup-powered, so main reset leaves it alone
    always_ff @(posedge clock) begin
        if (wipe) begin
            retainedTamper <= 1'b0;
        end else if (tamperLatchSet) begin
            retainedTamper <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        selfTestDone <= 1'b0;
        edidCopyDone <= 1'b0;
        // Result lines carry junk outside the done cycle
        selfTestFail <= ~failVec;
        if (reset) begin
            testCnt <= 5'h00;
            copyCnt <= 5'h00;
        end else begin
            copyCnt <= edidCopyEnable ? copyCnt + 5'h01 : 5'h00;
            if (edidCopyEnable && copyCnt == {1'b0, delay}) begin
                edidCopyDone <= 1'b1;
            end
            if (selfTestStart) begin
                testCnt <= {1'b0, delay} + 5'h01;
            end else if (testCnt != 5'h00) begin
                testCnt <= testCnt - 5'h01;
            end
            if (testCnt == 5'h01 && !silent) begin
                selfTestDone <= 1'b1;
                selfTestFail <= failVec;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/tsl_lockout.sv */
// Tamper and self-test lockout controller with AHB-Lite register slave
// Function
// - Display identification copied to computers once per power-up or reboot only.
// - Every computer-initiated write on the identification channel is blocked.
// - Tamper detection stays active, fed from backup supply, even without main power.
// - Backup supply failure or depletion enters the tampered state like a tamper.
// - Once tampered, device stays disabled and passes no peripheral data to computers.
// - A clear user indication is driven while tampered.
// - Tamper protection keeps internal programming ports unreachable from outside.
// - Self-tests run after every power-up and powered reset before normal operation.
// - Critical self-test failure stops the whole device or the failed part.
// - On self-test failure every input is isolated from every output.
// - Tamper protection failure forces isolation of peripherals from computers.
// - A clear visible indication is driven when a self-test has failed.
// - Switch has an unconnected isolation position, used when tampered or test failed.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tsl_lockout
    import tsl_pkg::*;
#(
    parameter int NUM_HOSTS = 2,
    parameter int NUM_PARTS = 4,
    parameter logic [NUM_PARTS-1:0] CRITICAL_MASK = 4'b0011,
    parameter int STEP_TIMEOUT = TSL_STEP_TIMEOUT_CYCLES,
    parameter int POS_W = $clog2(NUM_HOSTS + 1)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Always-on tamper detector pins
    input wire logic enclosureOpen,
    input wire logic backupFail,
    input wire logic retainedTamper,
    output logic tamperLatchSet,
    // Self-test engines
    output logic selfTestStart,
    input wire logic selfTestDone,
    input wire logic [NUM_PARTS-1:0] selfTestFail,
    // Display identification channel
    output logic edidCopyEnable,
    input wire logic edidCopyDone,
    input wire logic edidHostWrite,
    output logic edidWriteBlock,
    // Peripheral switch and part enables
    output logic [POS_W-1:0] switchPosition,
    output logic [NUM_PARTS-1:0] partEnable,
    // User indications and protection
    output logic tamperLed,
    output logic failLed,
    output logic progPortLock,
    output logic irq
);

    localparam int TIMER_W = $clog2(STEP_TIMEOUT + 1);

    tsl_state_e state;
    tsl_state_e next_state;
    logic [2:0] pinLevel;
    logic tamperNow;
    logic tampered;
    logic [TIMER_W-1:0] timer;
    logic timedOut;
    logic settled;
    logic [NUM_PARTS-1:0] failVector;
    logic testTimeout;
    logic edidCopied;
    logic [31:0] control;
    logic [TSL_NUM_EVENTS-1:0] irqStatus;
    logic [TSL_NUM_EVENTS-1:0] irqEnable;
    logic [TSL_NUM_EVENTS-1:0] events;
    logic [7:0] dataAddr;
    logic dataWrite;
    logic addrPhase;
    logic [3:0] hostSelect;

    function automatic logic [31:0] zext_events(input logic [TSL_NUM_EVENTS-1:0] v);
        zext_events = 32'h0000_0000;
        zext_events[TSL_NUM_EVENTS-1:0] = v;
    endfunction

    function automatic logic is_stop_state(input tsl_state_e s);
        is_stop_state = (s == TSL_ST_FAIL) || (s == TSL_ST_TAMPER);
    endfunction

    // Tamper detector pins come from the always-on domain
    tsl_sync #(
        .WIDTH(3)
    ) pinSync (
        .clock(clock),
        .reset(reset),
        .pinIn({retainedTamper, backupFail, enclosureOpen}),
        .level(pinLevel)
    );

    assign tamperNow = |pinLevel;
    assign timedOut = (timer == TIMER_W'(STEP_TIMEOUT));
    assign settled = (timer == TIMER_W'(TSL_SETTLE_CYCLES));
    assign hostSelect = control[TSL_CTRL_SEL_LSB +: TSL_CTRL_SEL_W];
    assign addrPhase = hsel && hready && htrans[1];

    // Tamper is sticky until reset; the backup latch brings it straight back
    always_ff @(posedge clock) begin
        if (reset) begin
            tampered <= 1'b0;
        end else if (tamperNow) begin
            tampered <= 1'b1;
        end
    end

    // Set request to the backup-powered retention latch
    always_ff @(posedge clock) begin
        if (reset) begin
            tamperLatchSet <= 1'b0;
        end else begin
            tamperLatchSet <= tampered || tamperNow;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            TSL_ST_START: begin
                // Wait for the pin filter so a retained tamper is seen first
                if (settled) begin
                    next_state = TSL_ST_TEST;
                end
            end
            TSL_ST_TEST: begin
                if (selfTestDone) begin
                    next_state = (|selfTestFail) ? TSL_ST_FAIL : TSL_ST_EDID;
                end else if (timedOut) begin
                    next_state = TSL_ST_FAIL;
                end
            end
            TSL_ST_EDID: begin
                if (edidCopyDone || timedOut) begin
                    next_state = TSL_ST_RUN;
                end
            end
            TSL_ST_RUN: next_state = TSL_ST_RUN;
            TSL_ST_FAIL: next_state = TSL_ST_FAIL;
            TSL_ST_TAMPER: next_state = TSL_ST_TAMPER;
            default: next_state = TSL_ST_FAIL;
        endcase
        if (tamperNow || tampered) begin
            next_state = TSL_ST_TAMPER;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= TSL_ST_START;
        end else begin
            state <= next_state;
        end
    end

    // Step timer, restarted on every state change
    always_ff @(posedge clock) begin
        if (reset) begin
            timer <= '0;
        end else if (next_state != state) begin
            timer <= '0;
        end else if (!timedOut) begin
            timer <= timer + TIMER_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            selfTestStart <= 1'b0;
        end else begin
            selfTestStart <= (state == TSL_ST_START) && (next_state == TSL_ST_TEST);
        end
    end

    // Failure record; a hung test counts as failure of every part
    always_ff @(posedge clock) begin
        if (reset) begin
            failVector <= '0;
            testTimeout <= 1'b0;
        end else if (state == TSL_ST_TEST) begin
            if (selfTestDone) begin
                failVector <= selfTestFail;
            end else if (timedOut) begin
                failVector <= '1;
                testTimeout <= 1'b1;
            end
        end
    end

    // Failed parts stop; a critical failure or a tamper stops all of them
    always_ff @(posedge clock) begin
        if (reset) begin
            partEnable <= '0;
        end else if (state == TSL_ST_TAMPER) begin
            partEnable <= '0;
        end else if (state == TSL_ST_FAIL) begin
            if (testTimeout || |(failVector & CRITICAL_MASK)) begin
                partEnable <= '0;
            end else begin
                partEnable <= ~failVector;
            end
        end else if (state == TSL_ST_RUN) begin
            partEnable <= '1;
        end else begin
            partEnable <= '0;
        end
    end

    // Host connected only in normal operation with a legal selection
    always_ff @(posedge clock) begin
        if (reset) begin
            switchPosition <= POS_W'(TSL_POS_ISOLATE);
        end else if (state == TSL_ST_RUN && !tamperNow && hostSelect != 4'h0
                     && 32'(hostSelect) <= NUM_HOSTS) begin
            switchPosition <= POS_W'(hostSelect);
        end else begin
            switchPosition <= POS_W'(TSL_POS_ISOLATE);
        end
    end

    // One copy per reset; the flag only falls with the next reset
    always_ff @(posedge clock) begin
        if (reset) begin
            edidCopied <= 1'b0;
        end else if (state == TSL_ST_EDID && (edidCopyDone || timedOut)) begin
            edidCopied <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            edidCopyEnable <= 1'b0;
        end else begin
            edidCopyEnable <= (next_state == TSL_ST_EDID) && !edidCopied;
        end
    end

    // Computer-side writes are never allowed, in any state
    always_ff @(posedge clock) begin
        if (reset) begin
            edidWriteBlock <= 1'b1;
        end else begin
            edidWriteBlock <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tamperLed <= 1'b0;
            failLed <= 1'b0;
        end else begin
            tamperLed <= tampered || tamperNow;
            failLed <= (state == TSL_ST_FAIL);
        end
    end

    // Unlock honoured only in normal operation; a tamper relocks at once
    always_ff @(posedge clock) begin
        if (reset) begin
            progPortLock <= 1'b1;
        end else begin
            progPortLock <= tampered || tamperNow || state != TSL_ST_RUN
                            || !control[TSL_CTRL_UNLOCK_BIT];
        end
    end

    // Event sources
    always_comb begin
        events = '0;
        events[TSL_EV_TAMPER] = tamperNow && !tampered;
        events[TSL_EV_TEST_FAIL] = (state != TSL_ST_FAIL) && (next_state == TSL_ST_FAIL);
        events[TSL_EV_TEST_PASS] = (state == TSL_ST_TEST) && (next_state == TSL_ST_EDID);
        events[TSL_EV_EDID_DONE] = (state == TSL_ST_EDID) && (next_state == TSL_ST_RUN);
        events[TSL_EV_EDID_WRITE] = edidHostWrite;
    end

    // Bus address phase captured; single word transfers only
    always_ff @(posedge clock) begin
        if (reset) begin
            dataAddr <= 8'h00;
            dataWrite <= 1'b0;
        end else begin
            dataAddr <= haddr[7:0];
            dataWrite <= addrPhase && hwrite;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            control <= TSL_CONTROL_RESET;
        end else if (dataWrite && dataAddr == TSL_OFF_CONTROL) begin
            control <= hwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irqEnable <= TSL_IRQ_ENABLE_RESET[TSL_NUM_EVENTS-1:0];
        end else if (dataWrite && dataAddr == TSL_OFF_IRQ_ENABLE) begin
            irqEnable <= hwdata[TSL_NUM_EVENTS-1:0];
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            irqStatus <= '0;
        end else if (dataWrite && dataAddr == TSL_OFF_IRQ_CLEAR) begin
            irqStatus <= (irqStatus & ~hwdata[TSL_NUM_EVENTS-1:0]) | events;
        end else begin
            irqStatus <= irqStatus | events;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    // Read data prepared at the address phase; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                TSL_OFF_CONTROL: hrdata <= control;
                TSL_OFF_STATE: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[TSL_STATE_CODE_LSB +: 4] <= 4'(state);
                    hrdata[TSL_STATE_TAMPER_BIT] <= tampered;
                    hrdata[TSL_STATE_COPIED_BIT] <= edidCopied;
                    hrdata[TSL_STATE_TIMEOUT_BIT] <= testTimeout;
                    hrdata[TSL_STATE_FAIL_LSB +: NUM_PARTS] <= failVector;
                end
                TSL_OFF_IRQ_STATUS: hrdata <= zext_events(irqStatus);
                TSL_OFF_IRQ_ENABLE: hrdata <= zext_events(irqEnable);
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge clock) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= is_stop_state(state) && 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: hdl/tsl_pkg.sv */
// Package: register map, field layout, reset values and timing of the lockout block
package tsl_pkg;

    // Register byte offsets
    localparam logic [7:0] TSL_OFF_CONTROL = 8'h00;
    localparam logic [7:0] TSL_OFF_STATE = 8'h04;
    localparam logic [7:0] TSL_OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] TSL_OFF_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] TSL_OFF_IRQ_ENABLE = 8'h10;

    // Control register fields
    localparam int TSL_CTRL_SEL_LSB = 0;
    localparam int TSL_CTRL_SEL_W = 4;
    localparam int TSL_CTRL_UNLOCK_BIT = 8;
    localparam logic [31:0] TSL_CONTROL_RESET = 32'h0000_0001;

    // State register fields
    localparam int TSL_STATE_CODE_LSB = 0;
    localparam int TSL_STATE_TAMPER_BIT = 4;
    localparam int TSL_STATE_COPIED_BIT = 5;
    localparam int TSL_STATE_TIMEOUT_BIT = 6;
    localparam int TSL_STATE_FAIL_LSB = 8;

    // Event bits, same layout in status, clear and enable
    localparam int TSL_EV_TAMPER = 0;
    localparam int TSL_EV_TEST_FAIL = 1;
    localparam int TSL_EV_TEST_PASS = 2;
    localparam int TSL_EV_EDID_DONE = 3;
    localparam int TSL_EV_EDID_WRITE = 4;
    localparam int TSL_NUM_EVENTS = 5;
    localparam logic [31:0] TSL_IRQ_ENABLE_RESET = 32'h0000_0000;

    // Switch position with no host connected
    localparam int TSL_POS_ISOLATE = 0;

    // Timing
    localparam int TSL_CLOCK_MHZ = 250;
    localparam int TSL_SETTLE_CYCLES = 4;
    localparam int TSL_STEP_TIMEOUT_US = 1000;
    localparam int TSL_STEP_TIMEOUT_CYCLES = TSL_STEP_TIMEOUT_US * TSL_CLOCK_MHZ;

    typedef enum {
        TSL_ST_START,
        TSL_ST_TEST,
        TSL_ST_EDID,
        TSL_ST_RUN,
        TSL_ST_FAIL,
        TSL_ST_TAMPER
    } tsl_state_e;

endpackage

/* File: hdl/tsl_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tsl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Only a settled value moves the level; stage1 is never looked at
    always_ff @(posedge clock) begin
        if (reset) begin
            level <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

endmodule
`default_nettype wire
